// >>> hdl/csb_checksum.sv
// bytewise crc-8 step (poly x^8+x^4+x^3+x^2+1, reflected register, data msb first)
module csb_checksum
  import csb_pkg::*;
(
  // clock and reset
  input  wire logic      hclk,
  input  wire logic      hresetn,
  // control
  input  wire logic      clear,
  input  wire logic      step,
  input  wire csb_byte_t data,
  // result
  output csb_byte_t      crc
);
  csb_byte_t crc_q;
  csb_byte_t crc_d;

  always_comb begin
    crc_d = crc_q;
    for (int i = 7; i >= 0; i--) begin
      if (crc_d[0] ^ data[i]) begin
        crc_d = (crc_d >> 1) ^ 8'hB8;
      end else begin
        crc_d = crc_d >> 1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_q <= 8'hFF;
    end else if (clear) begin
      crc_q <= 8'hFF;
    end else if (step) begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;
endmodule

// >>> hdl/csb_pkg.sv
// types shared by the channel status buffer files
package csb_pkg;
  typedef logic [7:0]  csb_byte_t;
  typedef logic [15:0] csb_word_t;
  typedef logic [4:0]  csb_widx_t;
  typedef enum logic [1:0] {
    CSB_IDLE,
    CSB_COPY,
    CSB_SUM
  } csb_copy_e;
endpackage

// >>> hdl/csb_regs.svh
// register map, field positions, reset values and timing counts of the status buffer
`ifndef CSB_REGS_SVH
`define CSB_REGS_SVH
`define CSB_OFS_CTRL        12'h000
`define CSB_OFS_STAT        12'h004
`define CSB_OFS_EBUF_BASE   12'h080
`define CSB_OFS_UBUF_BASE   12'h100
`define CSB_OFS_EBUF_IDX    12'h020
`define CSB_CTRL_INHIBIT    0
`define CSB_CTRL_TWO_BYTE   1
`define CSB_CTRL_CHAN_B     2
`define CSB_CTRL_IRQ_EN     3
`define CSB_CTRL_HW_MODE    4
`define CSB_CTRL_RST        5'h00
`define CSB_STAT_COPIED     0
`define CSB_STAT_IRQ        1
`define CSB_WORDS           24
`define CSB_BLOCK_BITS      192
`define CSB_BIT_PERIOD_NS   64
`define CSB_CLK_PERIOD_NS   8
`define CSB_BIT_CYCLES      (`CSB_BIT_PERIOD_NS / `CSB_CLK_PERIOD_NS)
`endif

// >>> hdl/csb_serializer.sv
// walks one transmit block bit by bit, most significant bit of each byte first
module csb_serializer
  import csb_pkg::*;
(
  // clock and reset
  input  wire logic      hclk,
  input  wire logic      hresetn,
  // transmit buffer read
  output csb_widx_t      rd_idx,
  input  wire csb_word_t rd_word,
  // serial status bits
  output logic           bit_a,
  output logic           bit_b,
  output logic           bit_strobe,
  output logic           block_end
);
  `include "csb_regs.svh"

  logic [7:0] bit_q;
  logic [3:0] div_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 4'h0;
      bit_q <= 8'h00;
      bit_strobe <= 1'b0;
      block_end <= 1'b0;
      bit_a <= 1'b0;
      bit_b <= 1'b0;
    end else begin
      bit_strobe <= 1'b0;
      block_end <= 1'b0;
      if (div_q == 4'(`CSB_BIT_CYCLES - 1)) begin
        div_q <= 4'h0;
        bit_strobe <= 1'b1;
        bit_a <= rd_word[15 - {5'h0, bit_q[2:0]}];
        bit_b <= rd_word[7 - {5'h0, bit_q[2:0]}];
        if (bit_q == 8'(`CSB_BLOCK_BITS - 1)) begin
          bit_q <= 8'h00;
          block_end <= 1'b1;
        end else begin
          bit_q <= bit_q + 8'h01;
        end
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  assign rd_idx = bit_q[7:3];
endmodule

// >>> hdl/csb_top.sv
// channel status block buffer: staging and transmit buffers behind an ahb-lite slave
module csb_top
  import csb_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // hardware-mode serial status input
  input  wire logic        ser_status_bit,
  input  wire logic        ser_status_valid,
  // serializer side
  output logic             status_bit_a,
  output logic             status_bit_b,
  output logic             status_bit_strobe,
  output logic             block_start,
  output logic             copy_irq
);
  `include "csb_regs.svh"

  // staging, transmit and user data buffers
  csb_word_t  ebuf_q [`CSB_WORDS];
  csb_word_t  fbuf_q [`CSB_WORDS];
  csb_word_t  ubuf_q [`CSB_WORDS];
  logic [4:0] ctrl_q;
  logic       copied_q;
  csb_copy_e  st_q;
  csb_widx_t  cidx_q;
  logic [7:0] ser_cnt_q;

  // bus address phase capture
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [11:0] addr_q;

  logic        ap_valid;
  csb_widx_t   tx_idx;
  csb_word_t   tx_word;
  logic        bit_a;
  logic        bit_b;
  logic        bit_stb;
  logic        blk_end;
  logic        crc_clear;
  logic        crc_step;
  csb_byte_t   crc_a;
  csb_byte_t   crc_b;

  function automatic logic in_buf(input logic [11:0] a, input logic [11:0] base);
    in_buf = (a >= base) && (a < base + 12'(4 * `CSB_WORDS)) && (a[1:0] == 2'b00);
  endfunction

  function automatic csb_widx_t buf_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    buf_idx = d[6:2];
  endfunction

  assign ap_valid = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      wr_pend_q <= ap_valid && hwrite;
      rd_pend_q <= ap_valid && !hwrite;
      if (ap_valid) begin
        addr_q <= haddr;
      end
    end
  end

  // control register: inhibit, access width, channel select, irq enable, hw mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `CSB_CTRL_RST;
    end else if (wr_pend_q && addr_q == `CSB_OFS_CTRL) begin
      ctrl_q <= hwdata[4:0];
    end
  end

  // copy flag: set by a copy, cleared by writing 1; set wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      copied_q <= 1'b0;
    end else if (st_q == CSB_SUM) begin
      copied_q <= 1'b1;
    end else if (wr_pend_q && addr_q == `CSB_OFS_STAT && hwdata[`CSB_STAT_COPIED]) begin
      copied_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      copy_irq <= 1'b0;
    end else begin
      copy_irq <= copied_q && ctrl_q[`CSB_CTRL_IRQ_EN];
    end
  end

  // staging buffer: bus writes and serial hardware-mode input
  generate
    for (genvar w = 0; w < `CSB_WORDS; w++) begin : g_ebuf
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ebuf_q[w] <= 16'h0000;
        end else if (ctrl_q[`CSB_CTRL_HW_MODE]) begin
          if (ser_status_valid && ser_cnt_q[7:3] == 5'(w)) begin
            ebuf_q[w][15 - {5'h0, ser_cnt_q[2:0]}] <= ser_status_bit;
            ebuf_q[w][7 - {5'h0, ser_cnt_q[2:0]}] <= ser_status_bit;
          end
        end else if (wr_pend_q && in_buf(addr_q, `CSB_OFS_EBUF_BASE)
                     && buf_idx(addr_q, `CSB_OFS_EBUF_BASE) == 5'(w)) begin
          if (ctrl_q[`CSB_CTRL_TWO_BYTE]) begin
            ebuf_q[w] <= hwdata[15:0];
          end else begin
            ebuf_q[w] <= {hwdata[7:0], hwdata[7:0]};
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ser_cnt_q <= 8'h00;
    end else if (ser_status_valid && ctrl_q[`CSB_CTRL_HW_MODE]) begin
      ser_cnt_q <= (ser_cnt_q == 8'(`CSB_BLOCK_BITS - 1)) ? 8'h00 : ser_cnt_q + 8'h01;
    end
  end

  // user data buffer: stored only, two-byte access
  generate
    for (genvar w = 0; w < `CSB_WORDS; w++) begin : g_ubuf
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ubuf_q[w] <= 16'h0000;
        end else if (wr_pend_q && in_buf(addr_q, `CSB_OFS_UBUF_BASE)
                     && buf_idx(addr_q, `CSB_OFS_UBUF_BASE) == 5'(w)) begin
          ubuf_q[w] <= hwdata[15:0];
        end
      end
    end
  endgenerate

  // block copy sequencer; one word per cycle, then checksum into last word for each channel whose pro flag is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= CSB_IDLE;
      cidx_q <= 5'h00;
    end else begin
      unique case (st_q)
        CSB_IDLE: begin
          if (blk_end && !ctrl_q[`CSB_CTRL_INHIBIT]) begin
            st_q <= CSB_COPY;
            cidx_q <= 5'h00;
          end
        end
        CSB_COPY: begin
          if (cidx_q == 5'(`CSB_WORDS - 1)) begin
            st_q <= CSB_SUM;
          end else begin
            cidx_q <= cidx_q + 5'h01;
          end
        end
        CSB_SUM: begin
          st_q <= CSB_IDLE;
        end
      endcase
    end
  end

  // each word lands long before the serializer first reads it, so no bit goes out stale
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int w = 0; w < `CSB_WORDS; w++) begin
        fbuf_q[w] <= 16'h0000;
      end
    end else if (st_q == CSB_COPY) begin
      fbuf_q[cidx_q] <= ebuf_q[cidx_q];
    end else if (st_q == CSB_SUM) begin
      // pro flag is the top bit of byte 0 of each channel
      if (fbuf_q[0][15]) begin
        fbuf_q[`CSB_WORDS - 1][15:8] <= crc_a;
      end
      if (fbuf_q[0][7]) begin
        fbuf_q[`CSB_WORDS - 1][7:0] <= crc_b;
      end
    end
  end

  assign crc_clear = (st_q == CSB_IDLE);
  assign crc_step  = (st_q == CSB_COPY) && (cidx_q != 5'(`CSB_WORDS - 1));

  csb_checksum u_crc_a (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clear   (crc_clear),
    .step    (crc_step),
    .data    (ebuf_q[cidx_q][15:8]),
    .crc     (crc_a)
  );

  csb_checksum u_crc_b (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clear   (crc_clear),
    .step    (crc_step),
    .data    (ebuf_q[cidx_q][7:0]),
    .crc     (crc_b)
  );

  assign tx_word = fbuf_q[tx_idx];

  csb_serializer u_ser (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .rd_idx     (tx_idx),
    .rd_word    (tx_word),
    .bit_a      (bit_a),
    .bit_b      (bit_b),
    .bit_strobe (bit_stb),
    .block_end  (blk_end)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_bit_a <= 1'b0;
      status_bit_b <= 1'b0;
      status_bit_strobe <= 1'b0;
      block_start <= 1'b0;
    end else begin
      status_bit_a <= bit_a;
      status_bit_b <= bit_b;
      status_bit_strobe <= bit_stb;
      block_start <= blk_end;
    end
  end

  // read data is registered in the address phase so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hrdata <= 32'h0000_0000;
      if (haddr == `CSB_OFS_CTRL) begin
        hrdata <= {27'h0, ctrl_q};
      end else if (haddr == `CSB_OFS_STAT) begin
        hrdata <= {30'h0, copy_irq, copied_q};
      end else if (in_buf(haddr, `CSB_OFS_EBUF_BASE)) begin
        if (ctrl_q[`CSB_CTRL_TWO_BYTE]) begin
          hrdata <= {16'h0, ebuf_q[buf_idx(haddr, `CSB_OFS_EBUF_BASE)]};
        end else if (ctrl_q[`CSB_CTRL_CHAN_B]) begin
          hrdata <= {24'h0, ebuf_q[buf_idx(haddr, `CSB_OFS_EBUF_BASE)][7:0]};
        end else begin
          hrdata <= {24'h0, ebuf_q[buf_idx(haddr, `CSB_OFS_EBUF_BASE)][15:8]};
        end
      end else if (in_buf(haddr, `CSB_OFS_UBUF_BASE)) begin
        hrdata <= {16'h0, ubuf_q[buf_idx(haddr, `CSB_OFS_UBUF_BASE)]};
      end
    end
  end

  // zero wait states, always okay; each access decodes its own haddr, no auto-increment
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule

// >>> sim/channel_status_block_buffer_test.sv
// self-checking bench for the channel status buffer
module channel_status_block_buffer_test import csb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        ser_status_bit = 1'b0;
  logic        ser_status_valid = 1'b0;
  logic        status_bit_a;
  logic        status_bit_b;
  logic        status_bit_strobe;
  logic        block_start;
  logic        copy_irq;
  logic        rd_ph = 1'b0;
  csb_word_t   stg [24];
  csb_word_t   ubw;
  logic        sb;
  logic [1:0]  sq [$];
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #4 hclk = ~hclk;
  csb_top u_csb_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ser_status_bit(ser_status_bit), .ser_status_valid(ser_status_valid),
    .status_bit_a(status_bit_a), .status_bit_b(status_bit_b),
    .status_bit_strobe(status_bit_strobe), .block_start(block_start), .copy_irq(copy_irq)
  );
  csb_host u_csb_host (
    .hclk(hclk), .hready(hreadyout), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic cmp_bits(input logic [1:0] exp, input logic [1:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic wait_start();
    do @(posedge hclk); while (block_start !== 1'b1);
  endtask
  // reference checksum: init all ones, reflected poly, bytes 0..22, msb first
  function automatic logic [7:0] sum8(input logic sel_b);
    logic [7:0] c;
    logic       fb;
    c = 8'hFF;
    for (int n = 0; n < 23; n++)
      for (int b = 7; b >= 0; b--) begin
        fb = c[0] ^ stg[n][sel_b ? b : b + 8];
        c = {1'b0, c[7:1]} ^ (fb ? 8'hB8 : 8'h00);
      end
    return c;
  endfunction
  // the strobe of the last old bit lands with block_start, so expectations go in one edge later
  task automatic check_block();
    wait_start();
    @(posedge hclk);
    for (int i = 0; i < 192; i++)
      sq.push_back({stg[i / 8][15 - i % 8], stg[i / 8][7 - i % 8]});
    wait_start();
    @(posedge hclk);
    cmp_word(32'h0, 32'(sq.size()));
  endtask
  // about eight blocks of 1536 cycles plus bus traffic and serial fill
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) cmp_word(u_csb_host.rq.pop_front(), hrdata);
    if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
    if (status_bit_strobe && sq.size() > 0)
      cmp_bits(sq.pop_front(), {status_bit_a, status_bit_b});
  end
  initial begin
    void'($urandom(32'h17192a59));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    u_csb_host.rd(12'h000, 32'h0);
    u_csb_host.rd(12'h004, 32'h0);
    u_csb_host.wr(12'h000, 32'h0B);
    u_csb_host.rd(12'h000, 32'h0B);
    for (int n = 0; n < 24; n++) begin
      stg[n] = 16'($urandom());
      if (n == 0) stg[n] = stg[n] & 16'h7F7F; // consumer block
      u_csb_host.wr(12'h080 + 12'(4 * n), {16'h0, stg[n]});
    end
    for (int n = 0; n < 24; n++)
      u_csb_host.rd(12'h080 + 12'(4 * n), {16'h0, stg[n]});
    u_csb_host.rd(12'h200, 32'h0);
    ubw = 16'($urandom());
    u_csb_host.wr(12'h15C, {16'h0, ubw});
    u_csb_host.rd(12'h15C, {16'h0, ubw});
    u_csb_host.rd(12'h160, 32'h0);
    for (int c = 0; c < 2; c++) begin
      u_csb_host.wr(12'h000, 32'h09 | 32'(c << 2));
      u_csb_host.rd(12'h098, {24'h0, (c == 1) ? stg[6][7:0] : stg[6][15:8]});
    end
    stg[5] = {2{stg[9][7:0]}};
    u_csb_host.wr(12'h094, {24'h0, stg[5][7:0]});
    u_csb_host.wr(12'h000, 32'h1B); // hardware mode ignores bus writes to the staging buffer
    u_csb_host.wr(12'h09C, {16'h0, ~stg[7]});
    u_csb_host.wr(12'h000, 32'h0B);
    u_csb_host.rd(12'h094, {16'h0, stg[5]});
    u_csb_host.rd(12'h09C, {16'h0, stg[7]});
    wait_start();
    wait_start();
    u_csb_host.rd(12'h004, 32'h0);
    u_csb_host.wr(12'h000, 32'h0A);
    do @(posedge hclk); while (copy_irq !== 1'b1);
    u_csb_host.rd(12'h004, 32'h3);
    stg[3] = 16'($urandom());
    u_csb_host.wr(12'h08C, {16'h0, stg[3]});
    u_csb_host.wr(12'h004, 32'h1);
    check_block();
    // hardware mode: serial status input of a professional block
    u_csb_host.wr(12'h000, 32'h1B);
    for (int i = 0; i < 192; i++) begin
      sb = (i == 0) ? 1'b1 : 1'($urandom());
      stg[i / 8][15 - i % 8] = sb;
      stg[i / 8][7 - i % 8] = sb;
      ser_status_bit <= sb;
      ser_status_valid <= 1'b1;
      @(posedge hclk);
    end
    ser_status_valid <= 1'b0;
    u_csb_host.rd(12'h080, {16'h0, stg[0]});
    stg[23] = {sum8(1'b0), sum8(1'b1)};
    u_csb_host.wr(12'h004, 32'h1);
    u_csb_host.wr(12'h000, 32'h1A);
    do @(posedge hclk); while (copy_irq !== 1'b1);
    check_block();
    give_verdict();
  end
endmodule

// >>> sim/csb_host.sv
// host model: ahb-lite master with single word transfers
module csb_host (
  // clock and handshake
  input  wire logic        hclk,
  input  wire logic        hready,
  // ahb-lite master
  output logic             hsel,
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rq [$];
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // a released data bus shows the inverse of the last word, never a stale match
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (!hready);
    htrans <= 2'b00;
    hwdata <= d; // a byte in [15:8], b byte in [7:0]
    do @(posedge hclk); while (!hready);
    hwdata <= ~d;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    xfer(a, 1'b0, 32'h0);
  endtask
endmodule

// >>> sim/csb_top_assertions.sv
// port-level checks of the status buffer top
module csb_chk (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // serial side
  input wire logic        status_bit_a,
  input wire logic        status_bit_b,
  input wire logic        status_bit_strobe,
  input wire logic        block_start,
  input wire logic        copy_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic        rd_take;
  logic        wr_take;
  logic        seen_q;
  logic [7:0]  scnt_q;
  logic [10:0] bage_q;
  logic [2:0]  wage_q;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  assign wr_take = hsel && hready && htrans[1] && hwrite;
  // the block cut short by reset is not counted; the last strobe of a block
  // coincides with block_start and is added in the check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scnt_q <= 8'h00;
      seen_q <= 1'b0;
    end else if (block_start) begin
      scnt_q <= 8'h00;
      seen_q <= 1'b1;
    end else if (status_bit_strobe) begin
      scnt_q <= scnt_q + 8'h01;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) bage_q <= 11'h7FF;
    else if (block_start) bage_q <= 11'h000;
    else if (bage_q != 11'h7FF) bage_q <= bage_q + 11'h001;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wage_q <= 3'h7;
    else if (wr_take) wage_q <= 3'h0;
    else if (wage_q != 3'h7) wage_q <= wage_q + 3'h1;
  end
  sequence strobe_gap_s;
    !status_bit_strobe [*7] ##1 status_bit_strobe;
  endsequence
  bit_period_a: assert property (status_bit_strobe |=> strobe_gap_s)
    else $error("strobe spacing wrong");
  bits_hold_a: assert property (!status_bit_strobe |-> $stable({status_bit_a, status_bit_b}))
    else $error("status bits moved without strobe");
  block_len_a: assert property (block_start && seen_q |-> scnt_q + 8'(status_bit_strobe) == 8'hC0)
    else $error("block length not 192 bits");
  block_pulse_a: assert property (block_start |=> !block_start [*8])
    else $error("block start too long");
  irq_cause_a: assert property ($rose(copy_irq) |-> bage_q <= 11'h028 || wage_q <= 3'h3)
    else $error("interrupt rose without copy");
  irq_clear_a: assert property ($fell(copy_irq) |-> wage_q <= 3'h3)
    else $error("interrupt fell without write");
  rdata_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata))
    else $error("read data moved");
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
endmodule
bind csb_top csb_chk u_csb_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .status_bit_a(status_bit_a), .status_bit_b(status_bit_b),
  .status_bit_strobe(status_bit_strobe), .block_start(block_start), .copy_irq(copy_irq)
);
